// file: hw/ldm_consts.vh
// Purpose: Named constants for the loss-of-signal detect and mute block.
// Assumes: Included by the detect and mute design file only, by its bare name.
// Notes: Register codes are word indexes, matched against haddr_in[3:2] of the bus address.
`ifndef LDM_CONSTS_VH
`define LDM_CONSTS_VH

`define LDM_NUM_CH 3
`define LDM_REG_STAT 2'h0
`define LDM_REG_DCTL 2'h1
`define LDM_REG_OCTL 2'h2
`define LDM_CH_LIMIT 4'h3

`define LDM_STAT_LOL 4
`define LDM_STAT_LOS 3
`define LDM_STAT_ALOS 2
`define LDM_STAT_DLOS 1
`define LDM_STAT_DMO 0

`define LDM_DCTL_CODEC 3
`define LDM_DCTL_ADIS 2
`define LDM_DCTL_DDIS 1
`define LDM_DCTL_EQ 0
`define LDM_OCTL_MUTE 3

`define LDM_DCTL_RESET 5'h00
`define LDM_OCTL_RESET 5'h00

`define LDM_MODE_E3 2'h0
`define LDM_MODE_STS1 2'h2

`define LDM_THR_E3 3'h0
`define LDM_THR_DS3_EQ 3'h1
`define LDM_THR_DS3_NOEQ 3'h2
`define LDM_THR_STS1_EQ 3'h3
`define LDM_THR_STS1_NOEQ 3'h4

`define LDM_QUAL_UI 5'd16
`define LDM_ZERO_RUN 8'd160
`define LDM_WIN_LAST 5'd31
`define LDM_MIN_ONES 4'd10
`define LDM_GOOD_LAST 3'd3

`define LDM_HTRANS_NONSEQ 2'h2

`endif

// file: hw/ldm_sync3.v
// Purpose: Three-stage synchroniser for pins from outside the system clock.
// Assumes: Each bit is an independent slow level.
// Notes: A bit changes only once the second and third stages agree.
`timescale 1ns/1ps
module ldm_sync3 #(
    parameter WIDTH = 32
) (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire [WIDTH-1:0] d_in,
    output reg [WIDTH-1:0] q_out
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;

    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
            q_out <= {WIDTH{1'b0}};
        end else begin
            s1_q <= d_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_out <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & q_out);
        end
    end
endmodule // ldm_sync3

// file: hw/ldm_los_detect_and_mute.v
// Purpose: Three-channel receive loss-of-signal detect, status and data mute.
// Assumes: 40 MHz system clock; recovered clock and pins are sampled inputs.
// Notes: Registers are reached over an AHB-Lite slave with zero wait states.
`timescale 1ns/1ps
`include "ldm_consts.vh"
module ldm_los_detect_and_mute (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output reg [31:0] hrdata_out,
    output reg hreadyout_out,
    output reg hresp_out,
    input wire [2:0] recovered_clock_in,
    input wire [2:0] rx_positive_rail_in,
    input wire [2:0] rx_negative_rail_in,
    input wire [2:0] amp_below_declare_in,
    input wire [2:0] amp_above_clear_in,
    input wire [2:0] lock_loss_flag_in,
    input wire [2:0] drive_monitor_flag_in,
    input wire [5:0] line_mode_in,
    input wire [2:0] rx_equalizer_enable_in,
    input wire host_mode_in,
    input wire global_mute_enable_pin_in,
    output wire [2:0] signal_loss_flag_out,
    output wire [2:0] rx_positive_rail_out,
    output wire [2:0] rx_negative_rail_out,
    output wire [8:0] amplitude_threshold_select_out,
    output wire [2:0] line_codec_disable_out
);
    wire [31:0] sy_w;
    wire [2:0] rclk_s;
    wire [2:0] pos_s;
    wire [2:0] neg_s;
    wire [2:0] below_s;
    wire [2:0] above_s;
    wire [2:0] lol_s;
    wire [2:0] dmo_s;
    wire [5:0] mode_s;
    wire [2:0] eq_s;
    wire host_s;
    wire gmute_s;
    wire [14:0] stat_w;
    wire [14:0] dctl_w;
    wire [14:0] octl_w;

    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg [31:0] rd_word_d;
    reg [4:0] rd_field_d;

    ldm_sync3 #(
        .WIDTH(32)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .d_in({
            global_mute_enable_pin_in,
            host_mode_in,
            rx_equalizer_enable_in,
            line_mode_in,
            drive_monitor_flag_in,
            lock_loss_flag_in,
            amp_above_clear_in,
            amp_below_declare_in,
            rx_negative_rail_in,
            rx_positive_rail_in,
            recovered_clock_in
        }),
        .q_out(sy_w)
    );

    assign {
        gmute_s,
        host_s,
        eq_s,
        mode_s,
        dmo_s,
        lol_s,
        above_s,
        below_s,
        neg_s,
        pos_s,
        rclk_s
    } = sy_w;

    wire addr_ok_w = (haddr_in[7:6] == 2'h0) && ({2'h0, haddr_in[5:4]} < `LDM_CH_LIMIT);
    wire take_w = hsel_in && (htrans_in == `LDM_HTRANS_NONSEQ) && hready_in;

    // Read mux for the word addressed in the current address phase.
    always @* begin
        rd_field_d = 5'h00;
        case (haddr_in[3:2])
            `LDM_REG_STAT: begin
                rd_field_d = stat_w[5*haddr_in[5:4] +: 5];
            end
            `LDM_REG_DCTL: begin
                rd_field_d = dctl_w[5*haddr_in[5:4] +: 5];
            end
            `LDM_REG_OCTL: begin
                rd_field_d = octl_w[5*haddr_in[5:4] +: 5];
            end
            default: begin
                rd_field_d = 5'h00;
            end
        endcase
        rd_word_d = addr_ok_w ? {27'h0, rd_field_d} : 32'h0;
    end

    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_out <= 32'h0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            wr_pend_q <= take_w && hwrite_in && addr_ok_w;
            if (take_w) begin
                wr_addr_q <= haddr_in[7:0];
            end
            if (take_w && !hwrite_in) begin
                hrdata_out <= rd_word_d;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < `LDM_NUM_CH; i = i + 1) begin : g_ch
            localparam integer CH_IDX = i;
            reg rclk_prev_q;
            reg raw_loss_q;
            reg [4:0] qual_cnt_q;
            reg alos_q;
            reg [7:0] zero_cnt_q;
            reg dlos_q;
            reg [4:0] win_cnt_q;
            reg [3:0] ones_cnt_q;
            reg [2:0] good_cnt_q;
            reg adis_q;
            reg ddis_q;
            reg eq_q;
            reg mute_q;
            reg flag_q;
            reg pos_q;
            reg neg_q;
            reg codec_q;
            reg [2:0] thr_q;
            reg [2:0] thr_d;
            reg [3:0] ones_d;

            wire my_wr_w = wr_pend_q && (wr_addr_q[5:4] == CH_IDX[1:0]);
            wire ui_w = rclk_s[i] && !rclk_prev_q;
            wire bit_w = pos_s[i] | neg_s[i];
            wire is_e3_w = (mode_s[2*i +: 2] == `LDM_MODE_E3);
            wire is_sts1_w = (mode_s[2*i +: 2] == `LDM_MODE_STS1);
            wire eq_eff_w = host_s ? eq_q : eq_s[i];
            wire adis_eff_w = host_s & adis_q;
            wire dig_on_w = !(host_s & ddis_q) && !is_e3_w;
            wire mute_eff_w = host_s ? mute_q : gmute_s;

            assign stat_w[5*i +: 5] = {
                lol_s[i],
                flag_q,
                alos_q,
                dlos_q,
                dmo_s[i]
            };
            assign dctl_w[5*i +: 5] = {1'b0, codec_q, adis_q, ddis_q,
                eq_q};
            assign octl_w[5*i +: 5] = {1'b0, mute_q, 3'h0};

            // Outputs come straight from the per-channel flops.
            assign signal_loss_flag_out[i] = flag_q;
            assign rx_positive_rail_out[i] = pos_q;
            assign rx_negative_rail_out[i] = neg_q;
            assign amplitude_threshold_select_out[3*i +: 3] = thr_q;
            assign line_codec_disable_out[i] = codec_q;

            always @* begin
                if (is_e3_w) begin
                    thr_d = `LDM_THR_E3;
                end else if (is_sts1_w) begin
                    thr_d = eq_eff_w ? `LDM_THR_STS1_EQ : `LDM_THR_STS1_NOEQ;
                end else begin
                    thr_d = eq_eff_w ? `LDM_THR_DS3_EQ : `LDM_THR_DS3_NOEQ;
                end
                ones_d = (ones_cnt_q == `LDM_MIN_ONES) ? ones_cnt_q :
                    ones_cnt_q + {3'h0, bit_w};
            end

            always @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    adis_q <= 1'b0;
                    ddis_q <= 1'b0;
                    eq_q <= 1'b0;
                    codec_q <= 1'b0;
                    mute_q <= 1'b0;
                end else if (my_wr_w) begin
                    if (wr_addr_q[3:2] == `LDM_REG_DCTL) begin
                        adis_q <= hwdata_in[`LDM_DCTL_ADIS];
                        ddis_q <= hwdata_in[`LDM_DCTL_DDIS];
                        eq_q <= hwdata_in[`LDM_DCTL_EQ];
                        codec_q <= hwdata_in[`LDM_DCTL_CODEC];
                    end
                    if (wr_addr_q[3:2] == `LDM_REG_OCTL) begin
                        mute_q <= hwdata_in[`LDM_OCTL_MUTE];
                    end
                end
            end

            always @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    rclk_prev_q <= 1'b0;
                    raw_loss_q <= 1'b0;
                    qual_cnt_q <= 5'h00;
                    alos_q <= 1'b0;
                    thr_q <= `LDM_THR_E3;
                end else begin
                    rclk_prev_q <= rclk_s[i];
                    thr_q <= thr_d;
                    if (below_s[i]) begin
                        raw_loss_q <= 1'b1;
                    end else if (above_s[i]) begin
                        raw_loss_q <= 1'b0;
                    end
                    if (adis_eff_w) begin
                        alos_q <= 1'b0;
                        qual_cnt_q <= 5'h00;
                    end else if (raw_loss_q == alos_q) begin
                        qual_cnt_q <= 5'h00;
                    end else if (ui_w) begin
                        if (qual_cnt_q == `LDM_QUAL_UI - 5'd1) begin
                            alos_q <= raw_loss_q;
                            qual_cnt_q <= 5'h00;
                        end else begin
                            qual_cnt_q <= qual_cnt_q + 5'd1;
                        end
                    end
                end
            end

            always @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    zero_cnt_q <= 8'h00;
                    dlos_q <= 1'b0;
                    win_cnt_q <= 5'h00;
                    ones_cnt_q <= 4'h0;
                    good_cnt_q <= 3'h0;
                end else if (!dig_on_w) begin
                    zero_cnt_q <= 8'h00;
                    dlos_q <= 1'b0;
                    win_cnt_q <= 5'h00;
                    ones_cnt_q <= 4'h0;
                    good_cnt_q <= 3'h0;
                end else if (ui_w) begin
                    if (bit_w) begin
                        zero_cnt_q <= 8'h00;
                    end else if (zero_cnt_q != `LDM_ZERO_RUN) begin
                        zero_cnt_q <= zero_cnt_q + 8'd1;
                    end
                    if (!dlos_q) begin
                        if (!bit_w && (zero_cnt_q == `LDM_ZERO_RUN - 8'd1)) begin
                            dlos_q <= 1'b1;
                            win_cnt_q <= 5'h00;
                            ones_cnt_q <= 4'h0;
                            good_cnt_q <= 3'h0;
                        end
                    end else if (win_cnt_q == `LDM_WIN_LAST) begin
                        win_cnt_q <= 5'h00;
                        ones_cnt_q <= 4'h0;
                        if (ones_d < `LDM_MIN_ONES) begin
                            good_cnt_q <= 3'h0;
                        end else if (good_cnt_q == `LDM_GOOD_LAST) begin
                            good_cnt_q <= 3'h0;
                            dlos_q <= 1'b0;
                        end else begin
                            good_cnt_q <= good_cnt_q + 3'd1;
                        end
                    end else begin
                        win_cnt_q <= win_cnt_q + 5'd1;
                        ones_cnt_q <= ones_d;
                    end
                end
            end

            always @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    flag_q <= 1'b0;
                    pos_q <= 1'b0;
                    neg_q <= 1'b0;
                end else begin
                    flag_q <= alos_q | dlos_q;
                    if (mute_eff_w && flag_q) begin
                        pos_q <= 1'b0;
                        neg_q <= 1'b0;
                    end else if (ui_w) begin
                        pos_q <= pos_s[i];
                        neg_q <= neg_s[i];
                    end
                end
            end
        end
    endgenerate
endmodule // ldm_los_detect_and_mute

// file: verif/ldm_los_assertions.sv
// Purpose: Port checker for the loss detect and mute block.
// Assumes: Channel 0 runs E3 and channel 1 DS3; eight clocks per unit interval.
// Notes: Amplitude hold times are counted in system clocks by helper counters.
`timescale 1ns/1ps
module ldm_los_checker (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire hreadyout_out,
    input wire hresp_out,
    input wire [2:0] amp_below_declare_in,
    input wire [2:0] amp_above_clear_in,
    input wire [5:0] line_mode_in,
    input wire [2:0] rx_equalizer_enable_in,
    input wire host_mode_in,
    input wire global_mute_enable_pin_in,
    input wire [2:0] signal_loss_flag_out,
    input wire [2:0] rx_positive_rail_out,
    input wire [2:0] rx_negative_rail_out,
    input wire [8:0] amplitude_threshold_select_out
);
    reg [10:0] below_q;
    reg [10:0] above_q;
    wire e3_hw = (line_mode_in[1:0] == 2'h0) && !host_mode_in;
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            below_q <= 11'h000;
            above_q <= 11'h000;
        end else begin
            below_q <= amp_below_declare_in[0] ? below_q + {10'h000, below_q != 11'h7ff} : 11'h000;
            above_q <= amp_above_clear_in[0] ? above_q + {10'h000, above_q != 11'h7ff} : 11'h000;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    sequence mute_on;
        (signal_loss_flag_out[0] && global_mute_enable_pin_in && !host_mode_in) [*8];
    endsequence
    ready_okay_a: assert property (hreadyout_out && !hresp_out)
        else $error("bus not ready or not okay");
    decl_early_a: assert property ($rose(signal_loss_flag_out[0])
        && line_mode_in[1:0] == 2'h0 |-> below_q >= 11'd80)
        else $error("loss declared too early");
    decl_late_a: assert property (below_q == 11'd2040 && e3_hw |-> signal_loss_flag_out[0])
        else $error("loss declared too late");
    clr_early_a: assert property ($fell(signal_loss_flag_out[0])
        && line_mode_in[1:0] == 2'h0 |-> above_q >= 11'd80)
        else $error("loss cleared too early");
    clr_late_a: assert property (above_q == 11'd2040 && e3_hw |-> !signal_loss_flag_out[0])
        else $error("loss cleared too late");
    mute_rails_a: assert property (mute_on
        |-> !rx_positive_rail_out[0] && !rx_negative_rail_out[0])
        else $error("rails not muted during loss");
    thr_e3_a: assert property ((line_mode_in[1:0] == 2'h0) [*8]
        |-> amplitude_threshold_select_out[2:0] == 3'h0) else $error("wrong E3 threshold");
    thr_ds3_a: assert property ((line_mode_in[3:2] == 2'h1
        && rx_equalizer_enable_in[1] && !host_mode_in) [*8]
        |-> amplitude_threshold_select_out[5:3] == 3'h1) else $error("wrong DS3 threshold");
endmodule // ldm_los_checker
bind ldm_los_detect_and_mute ldm_los_checker i_ldm_los_checker (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .amp_below_declare_in(amp_below_declare_in), .amp_above_clear_in(amp_above_clear_in),
    .line_mode_in(line_mode_in), .rx_equalizer_enable_in(rx_equalizer_enable_in),
    .host_mode_in(host_mode_in), .global_mute_enable_pin_in(global_mute_enable_pin_in),
    .signal_loss_flag_out(signal_loss_flag_out), .rx_positive_rail_out(rx_positive_rail_out),
    .rx_negative_rail_out(rx_negative_rail_out),
    .amplitude_threshold_select_out(amplitude_threshold_select_out));

// file: verif/ldm_line_source.sv
// Purpose: Line side model giving recovered clock and dual-rail data per channel.
// Assumes: Pattern code per channel: 0 all zeros, 1 one mark in four, 2 all marks.
// Notes: Clock runs free at 200 ns; data changes on the falling edge.
`timescale 1ns/1ps
module ldm_line_source (
    input wire [5:0] pattern_in,
    output reg [2:0] recovered_clock_out,
    output reg [2:0] pos_out,
    output reg [2:0] neg_out
);
    integer ui;
    integer i;
    reg mark;
    initial begin
        recovered_clock_out = 3'h0;
        pos_out = 3'h0;
        neg_out = 3'h0;
        ui = 0;
        #37;
        forever begin
            #100;
            recovered_clock_out = 3'h7;
            #100;
            recovered_clock_out = 3'h0;
            ui = ui + 1;
            for (i = 0; i < 3; i = i + 1) begin
                mark = pattern_in[2 * i + 1] || (pattern_in[2 * i] && (ui % 4 == 0));
                pos_out[i] = mark && ui[0];
                neg_out[i] = mark && !ui[0];
            end
        end
    end
endmodule // ldm_line_source

// file: verif/test_ldm_los_detect_and_mute.sv
// Purpose: Register, analog, digital, disable and mute tests.
// Assumes: Channel 0 E3, channel 1 DS3, channel 2 STS-1.
// Notes: Single word transfers; a loss wait gives up after 3000 clocks.
`timescale 1ns/1ps
module test_ldm_los_detect_and_mute;
    reg clk_sys_in = 1'b0;
    reg resetn_in = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg [2:0] below = 3'h0;
    reg [2:0] above = 3'h7;
    reg host = 1'b1;
    reg mute_pin = 1'b0;
    reg [5:0] pattern = 6'h2a;
    reg [31:0] rd;
    reg seen;
    wire [31:0] hrdata;
    wire hready;
    wire hresp;
    wire [2:0] rclk, rpos, rneg, flag, opos, oneg, codec;
    wire [8:0] thr;
    integer fail_count = 0;
    integer n_tests = 0;
    integer cycles = 0;
    integer n;
    always #12.5 clk_sys_in = ~clk_sys_in;
    ldm_line_source i_ldm_line_source (.pattern_in(pattern), .recovered_clock_out(rclk),
        .pos_out(rpos), .neg_out(rneg));
    ldm_los_detect_and_mute i_ldm_los_detect_and_mute (.clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .recovered_clock_in(rclk), .rx_positive_rail_in(rpos), .rx_negative_rail_in(rneg),
        .amp_below_declare_in(below), .amp_above_clear_in(above), .lock_loss_flag_in(3'h5),
        .drive_monitor_flag_in(3'h3), .line_mode_in(6'h24), .rx_equalizer_enable_in(3'h6),
        .host_mode_in(host), .global_mute_enable_pin_in(mute_pin),
        .signal_loss_flag_out(flag), .rx_positive_rail_out(opos), .rx_negative_rail_out(oneg),
        .amplitude_threshold_select_out(thr), .line_codec_disable_out(codec));
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    always @(posedge clk_sys_in) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            fail_count = fail_count + 1;
            final_report;
        end
    end
    task check(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [31:0] a, input [31:0] d);
        begin
            @(posedge clk_sys_in);
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= w;
            @(posedge clk_sys_in);
            while (hready !== 1'b1) @(posedge clk_sys_in);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk_sys_in);
            while (hready !== 1'b1) @(posedge clk_sys_in);
            rd = hrdata;
        end
    endtask
    task rdc(input [31:0] a, input [31:0] exp);
        begin
            bus(1'b0, a, 32'h0);
            check(rd, exp);
        end
    endtask
    task wait_flag(input integer ch, input v);
        begin
            n = 0;
            while (flag[ch] !== v && n < 3000) begin
                @(posedge clk_sys_in);
                n = n + 1;
            end
        end
    endtask
    task watch(input integer ch);
        begin
            seen = 1'b0;
            repeat (40) begin
                @(posedge clk_sys_in);
                seen = seen | opos[ch] | oneg[ch];
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        rdc(32'h00, 32'h11);
        bus(1'b1, 32'h00, 32'h1f);
        rdc(32'h00, 32'h11);
        rdc(32'h10, 32'h01);
        rdc(32'h14, 32'h00);
        bus(1'b1, 32'h14, 32'h0f);
        rdc(32'h14, 32'h0f);
        rdc(32'h18, 32'h00);
        bus(1'b1, 32'h18, 32'h1f);
        rdc(32'h18, 32'h08);
        bus(1'b1, 32'h30, 32'h1f);
        rdc(32'h30, 32'h00);
        rdc(32'h0c, 32'h00);
        repeat (8) @(posedge clk_sys_in);
        check(thr, 9'h108);
        check(codec, 3'h2);
        bus(1'b1, 32'h14, 32'h00);
        bus(1'b1, 32'h18, 32'h00);
        $display("test registers done");
        host <= 1'b0;
        mute_pin <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        check(thr, 9'h0c8);
        below <= 3'h1;
        above <= 3'h6;
        wait_flag(0, 1'b1);
        check(n >= 80 && n <= 2040, 1);
        repeat (10) @(posedge clk_sys_in);
        check({opos[0], oneg[0]}, 2'h0);
        rdc(32'h00, 32'h1d);
        repeat (2000) @(posedge clk_sys_in);
        below <= 3'h0;
        above <= 3'h7;
        wait_flag(0, 1'b0);
        check(n >= 80 && n <= 2040, 1);
        watch(0);
        check(seen, 1);
        $display("test analog done");
        pattern <= 6'h22;
        wait_flag(1, 1'b1);
        check(n >= 1272 && n <= 1296, 1);
        rdc(32'h10, 32'h0b);
        check({opos[1], oneg[1]}, 2'h0);
        pattern <= 6'h26;
        repeat (2000) @(posedge clk_sys_in);
        check(flag[1], 1);
        watch(1);
        check(seen, 0);
        pattern <= 6'h2a;
        wait_flag(1, 1'b0);
        check(n >= 768 && n <= 1304, 1);
        $display("test digital done");
        host <= 1'b1;
        mute_pin <= 1'b0;
        bus(1'b1, 32'h04, 32'h04);
        bus(1'b1, 32'h14, 32'h02);
        bus(1'b1, 32'h24, 32'h06);
        below <= 3'h5;
        above <= 3'h2;
        pattern <= 6'h02;
        repeat (2200) @(posedge clk_sys_in);
        check(flag, 3'h0);
        check(thr, 9'h110);
        rdc(32'h20, 32'h10);
        bus(1'b1, 32'h18, 32'h08);
        bus(1'b1, 32'h04, 32'h00);
        bus(1'b1, 32'h14, 32'h00);
        wait_flag(1, 1'b1);
        check(flag[1:0], 2'h3);
        pattern <= 6'h2a;
        watch(1);
        check(seen, 0);
        watch(0);
        check(seen, 1);
        $display("test disable and mute done");
        final_report;
    end
endmodule // test_ldm_los_detect_and_mute
